// file: common/osc_consts.vh
// Purpose: constants for the oscillator select and configuration block
// Assumes: configuration words are static while power-on reset is asserted
// Notes:   field positions, codes and erased values of the config words
`ifndef OSC_CONSTS_VH
`define OSC_CONSTS_VH
// ****************************************
// oscillator configuration word fields
// ****************************************
`define OSC_PMODE_LSB      0
`define OSC_PMODE_MSB      1
`define OSC_EFREQ_LSB      3
`define OSC_EFREQ_MSB      4
`define OSC_SECONDARY_OSC_PWR_BIT   5
`define OSC_CSM_LSB        6
`define OSC_CSM_MSB        7
`define OSC_CSM_SW_BIT     7
// ****************************************
// select config word fields
// ****************************************
`define OSC_NSEL_LSB       0
`define OSC_NSEL_MSB       2
// ****************************************
// erased values
// ****************************************
`define OSC_CFG_ERASED     8'hFF
`define OSC_SEL_ERASED     8'hFF
// ****************************************
// primary mode codes
// ****************************************
`define OSC_PM_EXT         2'h0
`define OSC_PM_XT          2'h1
`define OSC_PM_HS          2'h2
`define OSC_PM_OFF         2'h3
// ****************************************
// initial select codes
// ****************************************
`define OSC_NS_FRC         3'h0
`define OSC_NS_FAST_RC_WITH_PLL      3'h1
`define OSC_NS_PRI         3'h2
`define OSC_NS_PRIPLL      3'h3
`define OSC_NS_SEC         3'h4
`define OSC_NS_LOW_POWER_RC_OSC        3'h5
`define OSC_NS_SLOWDIV     3'h6
`define OSC_NS_FAST_RC_WITH_POSTSCALER      3'h7
// ****************************************
// source group codes on the group output
// ****************************************
`define OSC_GRP_PRI        2'h0
`define OSC_GRP_SEC        2'h1
`define OSC_GRP_FRC        2'h2
`define OSC_GRP_LOW_POWER_RC_OSC       2'h3
// ****************************************
// timing and divider
// ****************************************
`define OSC_CLK_MHZ        50
`define OSC_PLL_MULT       4
`define OSC_PS_W           3
`endif

// file: rtl/osc_cyc_div.v
// Purpose: divides the selected processor clock enable by two
// Assumes: i_en is a one-cycle enable marking each processor clock tick
// Notes:   gives an instruction tick and a half-rate square level
`timescale 1ns/1ps
module osc_cyc_div
(
  // clock and reset
  input  wire       i_clk,
  input  wire       i_rst,
  // processor tick in
  input  wire       i_en,
  // instruction tick and level out
  output reg        o_cy_en,
  output reg        o_cy_lvl
);

  // ****************************************
  // divide by two
  // ****************************************
  // toggle on every processor tick, pulse on every second
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_cy_lvl <= 1'b0;
      o_cy_en  <= 1'b0;
    end
    else
    begin
      o_cy_en <= i_en & o_cy_lvl;
      if (i_en)
        o_cy_lvl <= ~o_cy_lvl;
    end
  end

endmodule // osc_cyc_div

// file: rtl/osc_sel_cfg.v
// Purpose: picks the system clock source from the configuration words at
//          power-on reset, applies postscaler and pll, makes the cycle clock
// Assumes: source ticks arrive as one-cycle enables synchronous to I_CLK
// Notes:   the pll is modelled as a tick multiplier of four per source tick
//
// Operation
// - system clock comes from primary, secondary, fast rc or low-power rc
// - secondary oscillator power variant chosen by config bit five
// - fast rc offers an 8 MHz and a 500 kHz variant
// - low-power rc always runs in high-accuracy mode when selected
// - only primary and 8 MHz fast rc may use the four-times pll
// - fast rc may be reduced by a programmable postscaler
// - instruction clock is the processor clock divided by two
// - external clock primary mode drives the instruction clock on the output pin
// - source at power-on chosen by primary mode and initial select fields
// - erased configuration starts from 8 MHz fast rc with postscaler
// - ext clock range field bits 4:3 tunes power, erased means above 8 MHz
// - clock switching allowed only when switch/monitor bit seven is zero
// - fail-safe monitor active only when both switch/monitor bits are zero
// - mode 11 select 111 runs 8 MHz fast rc with postscaler
// - mode 11 select 110 runs 500 kHz fast rc with postscaler
// - select 101 mode 11 runs the low-power rc
// - select 100 mode 00 runs the secondary oscillator
// - select 011 mode 10 runs the high-speed crystal through the pll
// - select 011 mode 00 runs the external clock through the pll
// - select 010 runs primary without pll, type from the mode field
// - select 001 mode 11 runs 8 MHz fast rc through the pll
// - select 000 mode 11 runs plain 8 MHz fast rc
// - separate bit picks output pin as clock output or other function
`timescale 1ns/1ps
`include "osc_consts.vh"
module osc_sel_cfg
(
  // clock and reset
  input  wire       I_CLK,
  input  wire       I_RST,
  // configuration words
  input  wire [7:0] I_OSC_CFG,
  input  wire [7:0] I_OSC_SEL_CFG,
  input  wire       I_PIN_FUNC_SEL,
  // source ticks
  input  wire       I_PRI_TICK,
  input  wire       I_SEC_TICK,
  input  wire       I_FRC_TICK,
  input  wire       I_SLOW_FRC_TICK,
  input  wire       I_LOW_POWER_RC_OSC_TICK,
  // runtime controls
  input  wire [2:0] I_POSTSCALE,
  input  wire       I_SW_REQ,
  input  wire [2:0] I_SW_SEL,
  // source control out
  output reg  [1:0] O_SRC_GROUP,
  output reg  [2:0] O_CUR_SEL,
  output reg        O_PLL_ON,
  output reg        O_PS_ON,
  output reg        O_PRI_EN,
  output reg        O_SEC_EN,
  output reg        O_SEC_HIPWR,
  output reg        O_FRC_EN,
  output reg        O_SLOW_FRC_EN,
  output reg        O_LOW_POWER_RC_OSC_EN,
  output reg        O_LOW_POWER_RC_OSC_HIACC,
  output reg  [1:0] O_EXT_RANGE,
  output reg  [1:0] O_PRI_TYPE,
  output reg        O_CFG_BAD,
  // clock switch and monitor
  output reg        O_SW_EN,
  output reg        O_FAIL_SAFE_CLOCK_MONITOR_EN,
  output reg        O_SW_DONE,
  // clocks out
  output reg        O_SYS_TICK,
  output reg        O_CY_TICK,
  output reg        O_PIN_CLK_OUT,
  output reg        O_PIN_CLK_OE
);

  // ****************************************
  // configuration capture
  // ****************************************
  reg  [7:0] cfg;
  reg  [7:0] sel_cfg;
  reg        pin_func;
  reg  [2:0] cur_sel;
  reg        first;
  // latch config while reset is asserted, hold after release
  always @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      cfg      <= I_OSC_CFG;
      sel_cfg  <= I_OSC_SEL_CFG;
      pin_func <= I_PIN_FUNC_SEL;
    end
  end

  wire [1:0] pmode   = cfg[`OSC_PMODE_MSB:`OSC_PMODE_LSB];
  wire [1:0] csm     = cfg[`OSC_CSM_MSB:`OSC_CSM_LSB];
  wire       sw_ok   = ~cfg[`OSC_CSM_SW_BIT];
  wire       fail_safe_clock_monitor_ok = (csm == 2'b00);

  // ****************************************
  // source decode
  // ****************************************
  reg  [1:0] next_group;
  reg        next_pll;
  reg        next_ps;
  reg        next_slow;
  reg        next_bad;
  // map select and mode pair to a source
  always @*
  begin
    next_group = `OSC_GRP_FRC;
    next_pll   = 1'b0;
    next_ps    = 1'b0;
    next_slow  = 1'b0;
    next_bad   = 1'b0;
    case (cur_sel)
      `OSC_NS_FAST_RC_WITH_POSTSCALER:  next_ps = 1'b1;
      `OSC_NS_SLOWDIV:
      begin
        next_ps   = 1'b1;
        next_slow = 1'b1;
      end
      `OSC_NS_LOW_POWER_RC_OSC:    next_group = `OSC_GRP_LOW_POWER_RC_OSC;
      `OSC_NS_SEC:     next_group = `OSC_GRP_SEC;
      `OSC_NS_PRIPLL:
      begin
        next_group = `OSC_GRP_PRI;
        next_pll   = 1'b1;
        next_bad   = (pmode != `OSC_PM_HS) && (pmode != `OSC_PM_EXT);
      end
      `OSC_NS_PRI:
      begin
        next_group = `OSC_GRP_PRI;
        next_bad   = (pmode == `OSC_PM_OFF);
      end
      `OSC_NS_FAST_RC_WITH_PLL:  next_pll = 1'b1;
      `OSC_NS_FRC:     next_group = `OSC_GRP_FRC;
      default:         next_group = `OSC_GRP_FRC;
    endcase
  end

  // ****************************************
  // runtime switch
  // ****************************************
  // start from config, switch only when allowed
  always @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      cur_sel   <= `OSC_NS_FAST_RC_WITH_POSTSCALER;
      O_SW_DONE <= 1'b0;
    end
    else
    begin
      O_SW_DONE <= 1'b0;
      if (first)
        cur_sel <= sel_cfg[`OSC_NSEL_MSB:`OSC_NSEL_LSB];
      else if (I_SW_REQ && sw_ok)
      begin
        cur_sel   <= I_SW_SEL;
        O_SW_DONE <= 1'b1;
      end
    end
  end

  // first cycle after release loads config select
  always @(posedge I_CLK)
  begin
    if (I_RST)
      first <= 1'b1;
    else
      first <= 1'b0;
  end

  // ****************************************
  // postscaler and pll tick paths
  // ****************************************
  reg  [6:0] ps_cnt;
  reg  [1:0] pll_cnt;
  reg        pll_busy;
  wire       frc_tick = next_slow ? I_SLOW_FRC_TICK : I_FRC_TICK;
  wire [6:0] ps_lim   = (7'h01 << I_POSTSCALE) - 7'h01;
  reg        src_tick;
  // choose raw source tick
  always @*
  begin
    case (next_group)
      `OSC_GRP_PRI:  src_tick = I_PRI_TICK;
      `OSC_GRP_SEC:  src_tick = I_SEC_TICK;
      `OSC_GRP_LOW_POWER_RC_OSC: src_tick = I_LOW_POWER_RC_OSC_TICK;
      default:       src_tick = frc_tick;
    endcase
  end
  // divide fast rc by 2^postscale, or multiply by four with pll bursts
  always @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      ps_cnt     <= 7'h00;
      pll_cnt    <= 2'h0;
      pll_busy   <= 1'b0;
      O_SYS_TICK <= 1'b0;
    end
    else if (next_pll)
    begin
      // each source tick yields four system ticks
      O_SYS_TICK <= src_tick | pll_busy;
      if (src_tick)
      begin
        pll_busy <= 1'b1;
        pll_cnt  <= 2'h0;
      end
      else if (pll_busy)
      begin
        pll_cnt <= pll_cnt + 2'h1;
        if (pll_cnt == 2'h2)
          pll_busy <= 1'b0;
      end
    end
    else if (next_ps)
    begin
      O_SYS_TICK <= 1'b0;
      if (frc_tick)
      begin
        if (ps_cnt >= ps_lim)
        begin
          ps_cnt     <= 7'h00;
          O_SYS_TICK <= 1'b1;
        end
        else
          ps_cnt <= ps_cnt + 7'h01;
      end
    end
    else
      O_SYS_TICK <= src_tick;
  end

  // ****************************************
  // instruction clock
  // ****************************************
  wire cy_en;
  wire cy_lvl;
  osc_cyc_div u_cyc
  (
    .i_clk    (I_CLK),
    .i_rst    (I_RST),
    .i_en     (O_SYS_TICK),
    .o_cy_en  (cy_en),
    .o_cy_lvl (cy_lvl)
  );

  // ****************************************
  // registered outputs
  // ****************************************
  wire pri_clkout = (next_group == `OSC_GRP_PRI) && (pmode == `OSC_PM_EXT);
  // drive status, enables and pin
  always @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      O_SRC_GROUP   <= `OSC_GRP_FRC;
      O_CUR_SEL     <= `OSC_NS_FAST_RC_WITH_POSTSCALER;
      O_PLL_ON      <= 1'b0;
      O_PS_ON       <= 1'b1;
      O_PRI_EN      <= 1'b0;
      O_SEC_EN      <= 1'b0;
      O_SEC_HIPWR   <= 1'b1;
      O_FRC_EN      <= 1'b1;
      O_SLOW_FRC_EN <= 1'b0;
      O_LOW_POWER_RC_OSC_EN     <= 1'b0;
      O_LOW_POWER_RC_OSC_HIACC  <= 1'b0;
      O_EXT_RANGE   <= 2'h3;
      O_PRI_TYPE    <= `OSC_PM_OFF;
      O_CFG_BAD     <= 1'b0;
      O_SW_EN       <= 1'b0;
      O_FAIL_SAFE_CLOCK_MONITOR_EN     <= 1'b0;
      O_CY_TICK     <= 1'b0;
      O_PIN_CLK_OUT <= 1'b0;
      O_PIN_CLK_OE  <= 1'b0;
    end
    else
    begin
      O_SRC_GROUP   <= next_group;
      O_CUR_SEL     <= cur_sel;
      O_PLL_ON      <= next_pll;
      O_PS_ON       <= next_ps;
      O_PRI_EN      <= (next_group == `OSC_GRP_PRI);
      O_SEC_EN      <= (next_group == `OSC_GRP_SEC);
      O_SEC_HIPWR   <= cfg[`OSC_SECONDARY_OSC_PWR_BIT];
      O_FRC_EN      <= (next_group == `OSC_GRP_FRC) && !next_slow;
      O_SLOW_FRC_EN <= (next_group == `OSC_GRP_FRC) && next_slow;
      O_LOW_POWER_RC_OSC_EN     <= (next_group == `OSC_GRP_LOW_POWER_RC_OSC);
      O_LOW_POWER_RC_OSC_HIACC  <= (next_group == `OSC_GRP_LOW_POWER_RC_OSC);
      O_EXT_RANGE   <= cfg[`OSC_EFREQ_MSB:`OSC_EFREQ_LSB];
      O_PRI_TYPE    <= (next_group == `OSC_GRP_PRI) ? pmode : `OSC_PM_OFF;
      O_CFG_BAD     <= next_bad;
      O_SW_EN       <= sw_ok;
      O_FAIL_SAFE_CLOCK_MONITOR_EN     <= fail_safe_clock_monitor_ok;
      O_CY_TICK     <= cy_en;
      O_PIN_CLK_OUT <= pri_clkout & pin_func & cy_lvl;
      O_PIN_CLK_OE  <= pri_clkout & pin_func;
    end
  end

endmodule // osc_sel_cfg

// file: testbench/osc_sel_cfg_sva.sv
// Purpose: port assertions for the oscillator select block
// Assumes: config words are sampled on every edge while reset is high
// Notes:   checks other than p_sw_refuse and p_oe wait three cycles after release for outputs to settle
`timescale 1ns/1ps
module osc_sel_cfg_chk
(
  // clock and reset
  input wire       I_CLK,
  input wire       I_RST,
  // inputs watched
  input wire [7:0] I_OSC_CFG,
  input wire       I_SW_REQ,
  input wire [2:0] I_SW_SEL,
  // outputs watched
  input wire [1:0] O_SRC_GROUP,
  input wire [2:0] O_CUR_SEL,
  input wire       O_PLL_ON,
  input wire       O_SEC_HIPWR,
  input wire [1:0] O_EXT_RANGE,
  input wire [1:0] O_PRI_TYPE,
  input wire       O_SW_EN,
  input wire       O_FAIL_SAFE_CLOCK_MONITOR_EN,
  input wire       O_SW_DONE,
  input wire       O_SYS_TICK,
  input wire       O_CY_TICK,
  input wire       O_PIN_CLK_OE
);
  logic [7:0]  cfg_q;
  logic [2:0]  sel_q;
  logic [2:0]  cnt;
  logic [15:0] nsys;
  logic [1:0]  sys_d;
  logic [15:0] ncy;
  int          d;
  wire         ok = (cnt >= 3'h3);
  // ****************************************
  // helper state: latched config, settle count, tick counts
  // ****************************************
  always @(posedge I_CLK)
  begin
    if (I_RST)
      cfg_q <= I_OSC_CFG;
    cnt <= I_RST ? 3'h0 : (cnt == 3'h7 ? cnt : cnt + 3'h1);
    // system ticks delayed two cycles to line up with the cycle tick
    sys_d <= I_RST ? 2'h0 : {sys_d[0], O_SYS_TICK};
    nsys <= I_RST ? 16'h0000 : nsys + {15'h0000, sys_d[1]};
    ncy <= I_RST ? 16'h0000 : ncy + {15'h0000, O_CY_TICK};
    if (I_SW_REQ)
      sel_q <= I_SW_SEL;
  end
  assign d = int'(nsys) - 2 * int'(ncy);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  sequence s_req; ok && I_SW_REQ && !cfg_q[7]; endsequence
  sequence s_ack; s_req ##1 (O_SW_DONE && !I_SW_REQ); endsequence
  property p_sw_ack; s_req |=> O_SW_DONE; endproperty
  property p_sw_refuse; O_SW_DONE |-> $past(I_SW_REQ) && !cfg_q[7]; endproperty
  property p_sw_sel; s_ack |-> ##[0:2] (O_CUR_SEL == sel_q); endproperty
  property p_sw_en; ok |-> O_SW_EN == !cfg_q[7]; endproperty
  property p_fail_safe_clock_monitor; ok |-> O_FAIL_SAFE_CLOCK_MONITOR_EN == (cfg_q[7:6] == 2'h0); endproperty
  property p_fields; ok |-> {O_SEC_HIPWR, O_EXT_RANGE} == cfg_q[5:3]; endproperty
  property p_pll; ok && O_PLL_ON |-> O_CUR_SEL == 3'h1 || O_CUR_SEL == 3'h3; endproperty
  property p_cy; ok |-> d >= 0 && d <= 1; endproperty
  property p_oe; O_PIN_CLK_OE |-> O_PRI_TYPE == 2'h0 && O_SRC_GROUP == 2'h0; endproperty
  a_sw_ack: assert property (p_sw_ack)
    else $error("switch request not acknowledged");
  a_sw_refuse: assert property (p_sw_refuse)
    else $error("switch done without allowed request");
  a_sw_sel: assert property (p_sw_sel)
    else $error("switched select not applied");
  a_sw_en: assert property (p_sw_en)
    else $error("switch enable wrong");
  a_fail_safe_clock_monitor: assert property (p_fail_safe_clock_monitor)
    else $error("monitor enable wrong");
  a_fields: assert property (p_fields)
    else $error("power or range field wrong");
  a_pll: assert property (p_pll)
    else $error("pll on for a source without pll");
  a_cy: assert property (p_cy)
    else $error("cycle tick not half of system tick");
  a_oe: assert property (p_oe)
    else $error("pin clock out outside external mode");
endmodule // osc_sel_cfg_chk
bind osc_sel_cfg osc_sel_cfg_chk u_osc_sel_cfg_chk (.I_CLK(I_CLK), .I_RST(I_RST),
  .I_OSC_CFG(I_OSC_CFG), .I_SW_REQ(I_SW_REQ), .I_SW_SEL(I_SW_SEL),
  .O_SRC_GROUP(O_SRC_GROUP), .O_CUR_SEL(O_CUR_SEL), .O_PLL_ON(O_PLL_ON),
  .O_SEC_HIPWR(O_SEC_HIPWR), .O_EXT_RANGE(O_EXT_RANGE), .O_PRI_TYPE(O_PRI_TYPE),
  .O_SW_EN(O_SW_EN), .O_FAIL_SAFE_CLOCK_MONITOR_EN(O_FAIL_SAFE_CLOCK_MONITOR_EN), .O_SW_DONE(O_SW_DONE),
  .O_SYS_TICK(O_SYS_TICK), .O_CY_TICK(O_CY_TICK), .O_PIN_CLK_OE(O_PIN_CLK_OE));

// file: testbench/osc_tick_src.sv
// Purpose: model of an oscillator source giving one-cycle ticks
// Assumes: PERIOD of at least four cycles, as the pll needs
// Notes:   silent while not enabled, like a stopped crystal
`timescale 1ns/1ps
module osc_tick_src #(parameter int PERIOD = 6)
(
  // clock
  input  wire  i_clk,
  // enable from the block
  input  wire  i_en,
  // tick out
  output logic o_tick = 1'b0
);
  int cnt = 0;
  // count while enabled, restart when stopped
  always @(posedge i_clk)
  begin
    cnt <= (i_en !== 1'b1 || cnt == PERIOD - 1) ? 0 : cnt + 1;
    o_tick <= (i_en === 1'b1 && cnt == PERIOD - 1);
  end
endmodule // osc_tick_src

// file: testbench/tb_osc_sel_cfg.sv
// Purpose: self-checking bench for the oscillator select block
// Assumes: config words change only around power-on reset
// Notes:   table rows cover every start-up selection code
`timescale 1ns/1ps
module tb_osc_sel_cfg;
  typedef struct packed {logic [2:0] sel; logic [1:0] mode;
    logic [1:0] grp; logic pll; logic ps;} osc_row_t;
  logic       I_CLK, I_RST, I_PIN_FUNC_SEL, I_SW_REQ;
  logic [7:0] I_OSC_CFG, I_OSC_SEL_CFG, c;
  logic [2:0] I_POSTSCALE, I_SW_SEL;
  wire  [4:0] tick, en;
  wire  [1:0] O_SRC_GROUP, O_EXT_RANGE, O_PRI_TYPE;
  wire  [2:0] O_CUR_SEL;
  wire        O_PLL_ON, O_PS_ON, O_PRI_EN, O_SEC_EN, O_SEC_HIPWR, O_FRC_EN, O_SLOW_FRC_EN;
  wire        O_LOW_POWER_RC_OSC_EN, O_SW_EN, O_FAIL_SAFE_CLOCK_MONITOR_EN, O_SW_DONE, O_SYS_TICK, O_CY_TICK, O_PIN_CLK_OE;
  wire        O_LOW_POWER_RC_OSC_HIACC, O_CFG_BAD, O_PIN_CLK_OUT;
  int         failures, tests_run, nsys, ncy, npri, ndone, cyc, b0, b1, npin, nfrc;
  osc_row_t   rows [0:10];
  // ****************************************
  // clock, tick counters and timeout
  // ****************************************
  initial
  begin
    I_CLK = 1'b0;
    forever #10 I_CLK = ~I_CLK;
  end
  always @(posedge I_CLK)
  begin
    cyc++;
    nsys += (O_SYS_TICK === 1'b1);
    ncy += (O_CY_TICK === 1'b1);
    npri += (tick[0] === 1'b1);
    ndone += (O_SW_DONE === 1'b1);
    npin += (O_PIN_CLK_OUT === 1'b1);
    nfrc += (tick[2] === 1'b1);
    if (cyc == 5000)
    begin
      failures++;
      test_done();
    end
  end
  // ****************************************
  // sources and design
  // ****************************************
  assign en = {O_LOW_POWER_RC_OSC_EN, O_SLOW_FRC_EN, O_FRC_EN, O_SEC_EN, O_PRI_EN};
  osc_tick_src #(.PERIOD(6)) u_osc_tick_src [4:0] (.i_clk(I_CLK), .i_en(en), .o_tick(tick));
  osc_sel_cfg u_osc_sel_cfg (.I_CLK(I_CLK), .I_RST(I_RST), .I_OSC_CFG(I_OSC_CFG),
    .I_OSC_SEL_CFG(I_OSC_SEL_CFG), .I_PIN_FUNC_SEL(I_PIN_FUNC_SEL), .I_PRI_TICK(tick[0]),
    .I_SEC_TICK(tick[1]), .I_FRC_TICK(tick[2]), .I_SLOW_FRC_TICK(tick[3]),
    .I_LOW_POWER_RC_OSC_TICK(tick[4]), .I_POSTSCALE(I_POSTSCALE), .I_SW_REQ(I_SW_REQ),
    .I_SW_SEL(I_SW_SEL), .O_SRC_GROUP(O_SRC_GROUP), .O_CUR_SEL(O_CUR_SEL),
    .O_PLL_ON(O_PLL_ON), .O_PS_ON(O_PS_ON), .O_PRI_EN(O_PRI_EN), .O_SEC_EN(O_SEC_EN),
    .O_SEC_HIPWR(O_SEC_HIPWR), .O_FRC_EN(O_FRC_EN), .O_SLOW_FRC_EN(O_SLOW_FRC_EN),
    .O_LOW_POWER_RC_OSC_EN(O_LOW_POWER_RC_OSC_EN), .O_LOW_POWER_RC_OSC_HIACC(O_LOW_POWER_RC_OSC_HIACC), .O_EXT_RANGE(O_EXT_RANGE),
    .O_PRI_TYPE(O_PRI_TYPE), .O_CFG_BAD(O_CFG_BAD), .O_SW_EN(O_SW_EN), .O_FAIL_SAFE_CLOCK_MONITOR_EN(O_FAIL_SAFE_CLOCK_MONITOR_EN),
    .O_SW_DONE(O_SW_DONE), .O_SYS_TICK(O_SYS_TICK), .O_CY_TICK(O_CY_TICK),
    .O_PIN_CLK_OUT(O_PIN_CLK_OUT), .O_PIN_CLK_OE(O_PIN_CLK_OE));
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // reset with given words, then invert them to show they are held
  task automatic rst(input logic [7:0] cw, input logic [7:0] sel);
    @(posedge I_CLK);
    I_OSC_CFG <= cw;
    I_OSC_SEL_CFG <= sel;
    I_RST <= 1'b1;
    repeat (3) @(posedge I_CLK);
    I_RST <= 1'b0;
    I_OSC_CFG <= ~cw;
    I_OSC_SEL_CFG <= ~sel;
    repeat (5) @(posedge I_CLK);
    #1;
  endtask
  // one request, or two back to back
  task automatic sw(input logic [2:0] a, input logic [2:0] b, input int n);
    @(posedge I_CLK);
    I_SW_REQ <= 1'b1;
    I_SW_SEL <= a;
    if (n == 2)
    begin
      @(posedge I_CLK);
      I_SW_SEL <= b;
    end
    @(posedge I_CLK);
    I_SW_REQ <= 1'b0;
    repeat (4) @(posedge I_CLK);
    #1;
  endtask
  task automatic test_done();
    $display("tests_run=%0d failures=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    rows = '{'{3'h7, 2'h3, 2'h2, 1'h0, 1'h1}, '{3'h6, 2'h3, 2'h2, 1'h0, 1'h1},
      '{3'h5, 2'h3, 2'h3, 1'h0, 1'h0}, '{3'h4, 2'h0, 2'h1, 1'h0, 1'h0},
      '{3'h3, 2'h2, 2'h0, 1'h1, 1'h0}, '{3'h3, 2'h0, 2'h0, 1'h1, 1'h0},
      '{3'h2, 2'h2, 2'h0, 1'h0, 1'h0}, '{3'h2, 2'h1, 2'h0, 1'h0, 1'h0},
      '{3'h2, 2'h0, 2'h0, 1'h0, 1'h0}, '{3'h1, 2'h3, 2'h2, 1'h1, 1'h0},
      '{3'h0, 2'h3, 2'h2, 1'h0, 1'h0}};
    I_RST = 1'b1;
    I_OSC_CFG = 8'hFF;
    I_OSC_SEL_CFG = 8'hFF;
    I_PIN_FUNC_SEL = 1'b1;
    I_SW_REQ = 1'b0;
    I_SW_SEL = 3'h0;
    I_POSTSCALE = 3'h1;
    repeat (20) @(posedge I_CLK);
    // table of start-up selections
    for (int i = 0; i < 11; i++)
    begin
      c = {3'(i), 2'(i + 1), 1'h1, rows[i].mode};
      rst(c, {5'h1F, rows[i].sel});
      chk({1'h0, O_SRC_GROUP, O_CUR_SEL, O_PLL_ON, O_PS_ON}, {1'h0, rows[i].grp,
        rows[i].sel, rows[i].pll, rows[i].ps});
      chk({1'h0, O_PRI_TYPE, O_EXT_RANGE, O_SEC_HIPWR, O_SW_EN, O_FAIL_SAFE_CLOCK_MONITOR_EN},
        {1'h0, (rows[i].grp == 2'h0) ? rows[i].mode : 2'h3, c[4:3], c[5], ~c[7],
        c[7:6] == 2'h0});
      chk({3'h0, en}, 8'h01 << (int'(rows[i].grp) + (rows[i].grp == 2'h3)
        + (rows[i].sel == 3'h6)));
      chk({6'h00, O_LOW_POWER_RC_OSC_HIACC, O_CFG_BAD}, {6'h00, rows[i].grp == 2'h3, 1'h0});
    end
    // primary selected with its mode field off flags a bad config
    rst(8'h3F, 8'h02);
    chk({7'h00, O_CFG_BAD}, 8'h01);
    // erased words, switching locked out
    rst(8'hFF, 8'hFF);
    chk({1'h0, O_SRC_GROUP, O_CUR_SEL, O_PLL_ON, O_PS_ON}, 8'h5D);
    chk({4'h0, O_EXT_RANGE, O_SW_EN, O_FAIL_SAFE_CLOCK_MONITOR_EN}, 8'h0C);
    b0 = ndone;
    sw(3'h4, 3'h0, 1);
    chk(8'(ndone - b0), 8'h00);
    chk({5'h00, O_CUR_SEL}, 8'h07);
    // postscaler at divide by four, one system tick per four fast rc ticks
    @(posedge I_CLK);
    I_POSTSCALE <= 3'h2;
    #1;
    b0 = nsys;
    b1 = nfrc;
    repeat (240) @(posedge I_CLK);
    #1;
    chk({7'h00, ((nfrc - b1) - 4 * (nsys - b0)) inside {[-8:8]}}, 8'h01);
    // crystal without pll, cycle tick at half rate
    rst(8'h3E, 8'h02);
    b0 = nsys;
    b1 = ncy;
    repeat (240) @(posedge I_CLK);
    #1;
    chk({7'h00, (nsys - b0) > 20}, 8'h01);
    chk({7'h00, ((nsys - b0) - 2 * (ncy - b1)) inside {[-2:2]}}, 8'h01);
    // external clock drives the pin only while the pin is selected
    rst(8'h3C, 8'h02);
    b0 = npin;
    repeat (48) @(posedge I_CLK);
    #1;
    chk({6'h00, O_PIN_CLK_OE, (npin - b0) > 0 && (npin - b0) < 48}, 8'h03);
    // pin function bit is configuration, taken only during reset
    @(posedge I_CLK);
    I_PIN_FUNC_SEL <= 1'b0;
    rst(8'h3C, 8'h02);
    b0 = npin;
    repeat (48) @(posedge I_CLK);
    #1;
    chk({6'h00, O_PIN_CLK_OE, npin != b0}, 8'h00);
    // external clock through the pll, four system ticks per source tick
    rst(8'h3C, 8'h03);
    b0 = nsys;
    b1 = npri;
    repeat (240) @(posedge I_CLK);
    #1;
    chk({7'h00, ((nsys - b0) - 4 * (npri - b1)) inside {[-8:8]}}, 8'h01);
    // back to back switches, last one wins
    b0 = ndone;
    sw(3'h4, 3'h5, 2);
    chk(8'(ndone - b0), 8'h02);
    chk({2'h0, O_SRC_GROUP, O_CUR_SEL, O_FAIL_SAFE_CLOCK_MONITOR_EN}, 8'h3B);
    test_done();
  end
endmodule // tb_osc_sel_cfg
